/* apc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module apc_top (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    output logic [1:0] status_diag_out,
    input wire logic [3:0] pixel_in,
    input wire logic [7:0] pixel8_in,
    input wire logic [7:0] char_code_in,
    input wire logic [7:0] attr_in,
    input wire logic ninth_dot_in,
    input wire logic eighth_dot_in,
    input wire logic fg_dot_in,
    input wire logic line_cmp_in,
    input wire logic vsync_in,
    input wire logic nine_dot_in,
    output logic [7:0] color_out,
    output logic [3:0] pan_shift_out,
    output logic text_mode_out,
    output logic blink_mode_out
);
    typedef struct packed {
        logic data_phase;
        logic [5:0] index;
        logic [7:0] mode;
        logic [7:0] border;
        logic [7:0] plane;
        logic [7:0] pan;
        logic [7:0] csel;
        logic pan_force;
        logic [7:0] rdata;
        logic [1:0] diag;
        logic [7:0] color;
        logic [3:0] shift;
        logic [4:0] blink_cnt;
        logic blink_phase;
        logic text_mode;
        logic vs_lvl;
    } apc_state_t;

    apc_state_t st_r;
    apc_state_t st_nxt;
    logic [2:0] vs_sync_r;
    logic [5:0] pal_host;
    logic [5:0] pal_pix;
    logic pal_we;
    logic [3:0] pix_idx;
    logic [3:0] pix_mask;
    logic [7:0] final_col;
    logic bg_dot;
    logic [3:0] attr_nib;

    // Vsync from the CRT side, three-stage
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            vs_sync_r <= 3'b000;
        end else begin
            vs_sync_r <= {vs_sync_r[1:0], vsync_in};
        end
    end

    // Palette writes only while host owns it
    assign pal_we = io_wr_in && io_addr_in == apc_pkg::ATTR_WR_PORT && st_r.data_phase
        && st_r.index[4] == 1'b0 && !st_r.index[apc_pkg::IDX_PAS_BIT];

    // Pixel index: text uses attribute nibble, graphics uses planes
    always_comb begin
        bg_dot = 1'b0;
        attr_nib = attr_in[3:0];
        if (!st_r.mode[apc_pkg::MODE_GFX_BIT]) begin
            bg_dot = ninth_dot_in ? ((st_r.mode[apc_pkg::MODE_LGE_BIT]
                && char_code_in >= apc_pkg::LG_LO && char_code_in <= apc_pkg::LG_HI)
                ? !eighth_dot_in : 1'b1) : !fg_dot_in;
            if (st_r.mode[apc_pkg::MODE_BLINK_BIT]) begin
                attr_nib = bg_dot ? {1'b0, attr_in[6:4]} : attr_in[3:0];
                if (!bg_dot && attr_in[7] && st_r.blink_phase) begin
                    attr_nib = {1'b0, attr_in[6:4]};
                end
            end else begin
                attr_nib = bg_dot ? attr_in[7:4] : attr_in[3:0];
            end
        end
    end

    assign pix_mask = st_r.plane[3:0];
    assign pix_idx = (st_r.mode[apc_pkg::MODE_GFX_BIT] ? pixel_in : attr_nib) & pix_mask;

    apc_palette_mem #(.DEPTH(16), .WIDTH(6)) u_pal (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .wr_en_in(pal_we),
        .wr_addr_in(st_r.index[3:0]),
        .wr_data_in(io_wdata_in[5:0]),
        .host_addr_in(st_r.index[3:0]),
        .pix_addr_in(pix_idx),
        .host_data_out(pal_host),
        .pix_data_out(pal_pix)
    );

    // Colour formation from palette and select
    always_comb begin
        final_col = {st_r.csel[3:2], pal_pix};
        if (st_r.mode[apc_pkg::MODE_CSRC_BIT]) begin
            final_col[5:4] = st_r.csel[1:0];
        end
        if (st_r.mode[apc_pkg::MODE_256_BIT]) begin
            final_col = pixel8_in;
        end
        if (!st_r.index[apc_pkg::IDX_PAS_BIT]) begin
            final_col = st_r.border;
        end
    end

    // Next-state logic for port, registers and video
    always_comb begin
        st_nxt = st_r;
        if (io_rd_in && io_addr_in == apc_pkg::STATUS_PORT) begin
            st_nxt.data_phase = 1'b0;
        end else if (io_wr_in && io_addr_in == apc_pkg::ATTR_WR_PORT) begin
            st_nxt.data_phase = !st_r.data_phase;
            if (!st_r.data_phase) begin
                st_nxt.index = io_wdata_in[5:0];
            end else begin
                case (st_r.index[4:0])
                    apc_pkg::IDX_MODE: st_nxt.mode = io_wdata_in;
                    apc_pkg::IDX_BORDER: st_nxt.border = io_wdata_in;
                    apc_pkg::IDX_PLANE: st_nxt.plane = {2'b00, io_wdata_in[5:0]};
                    apc_pkg::IDX_PAN: st_nxt.pan = {4'h0, io_wdata_in[3:0]};
                    apc_pkg::IDX_CSEL: st_nxt.csel = {4'h0, io_wdata_in[3:0]};
                    default: st_nxt.mode = st_r.mode;
                endcase
            end
        end
        if (io_rd_in && io_addr_in == apc_pkg::ATTR_RD_PORT) begin
            case (st_r.index[4:0])
                apc_pkg::IDX_MODE: st_nxt.rdata = st_r.mode;
                apc_pkg::IDX_BORDER: st_nxt.rdata = st_r.border;
                apc_pkg::IDX_PLANE: st_nxt.rdata = st_r.plane;
                apc_pkg::IDX_PAN: st_nxt.rdata = st_r.pan;
                apc_pkg::IDX_CSEL: st_nxt.rdata = st_r.csel;
                default: st_nxt.rdata = st_r.index[4] ? 8'h00 : {2'b00, pal_host};
            endcase
        end else if (io_rd_in && io_addr_in == apc_pkg::ATTR_WR_PORT) begin
            st_nxt.rdata = {2'b00, st_r.index};
        end
        // Status mux of colour pairs
        case (st_r.plane[5:4])
            2'b00: st_nxt.diag = {st_r.color[2], st_r.color[0]};
            2'b01: st_nxt.diag = {st_r.color[5], st_r.color[4]};
            2'b10: st_nxt.diag = {st_r.color[3], st_r.color[1]};
            default: st_nxt.diag = {st_r.color[7], st_r.color[6]};
        endcase
        // Split-screen pan suppression
        if (vs_sync_r[2] && vs_sync_r[1]) begin
            st_nxt.pan_force = 1'b0;
        end else if (line_cmp_in && st_r.mode[apc_pkg::MODE_PANC_BIT]) begin
            st_nxt.pan_force = 1'b1;
        end
        if (!st_r.mode[apc_pkg::MODE_PANC_BIT]) begin
            st_nxt.pan_force = 1'b0;
        end
        // Shift amount per mode
        if (st_r.pan_force) begin
            st_nxt.shift = 4'h0;
        end else if (nine_dot_in && !st_r.mode[apc_pkg::MODE_GFX_BIT]) begin
            st_nxt.shift = st_r.pan[3:0] >= 4'h8 ? 4'h0 : st_r.pan[3:0] + 4'h1;
        end else if (st_r.mode[apc_pkg::MODE_256_BIT]) begin
            st_nxt.shift = {1'b0, st_r.pan[3:1]};
        end else begin
            st_nxt.shift = st_r.pan[3:0] > 4'h8 ? 4'h8 : st_r.pan[3:0];
        end
        st_nxt.color = final_col;
        // Text flag registered with the mode it follows
        st_nxt.text_mode = !st_nxt.mode[apc_pkg::MODE_GFX_BIT];
        // Settled vsync level, taken once the last two stages agree
        if (vs_sync_r[1] == vs_sync_r[2]) begin
            st_nxt.vs_lvl = vs_sync_r[2];
        end
        // Blink phase counts settled vsync rises
        if (vs_sync_r[1] && vs_sync_r[2] && !st_r.vs_lvl) begin
            if (st_r.blink_cnt == 5'(apc_pkg::BLINK_CYCLES - 1)) begin
                st_nxt.blink_cnt = 5'h00;
                st_nxt.blink_phase = !st_r.blink_phase;
            end else begin
                st_nxt.blink_cnt = st_r.blink_cnt + 5'h01;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign io_rdata_out = st_r.rdata;
    assign status_diag_out = st_r.diag;
    assign color_out = st_r.color;
    assign pan_shift_out = st_r.shift;
    assign text_mode_out = st_r.text_mode;
    assign blink_mode_out = st_r.mode[apc_pkg::MODE_BLINK_BIT];

    // Status read returns pointer to index
    ptr_reset_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (io_rd_in && io_addr_in == apc_pkg::STATUS_PORT) |=> !st_r.data_phase)
        else $error("pointer not reset by status read");
    // Each port write flips the pointer
    ptr_toggle_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (io_wr_in && io_addr_in == apc_pkg::ATTR_WR_PORT && !io_rd_in)
        |=> st_r.data_phase != $past(st_r.data_phase))
        else $error("pointer did not alternate");
    // Index-phase write loads the index
    idx_load_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (io_wr_in && io_addr_in == apc_pkg::ATTR_WR_PORT && !st_r.data_phase)
        |=> st_r.index == $past(io_wdata_in[5:0]))
        else $error("index not loaded");
    // Read of the write port shows the index
    idx_read_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (io_rd_in && io_addr_in == apc_pkg::ATTR_WR_PORT)
        |=> io_rdata_out == {2'b00, $past(st_r.index)})
        else $error("index read back wrong");
    // Colour set bits on top of the code
    csel_high_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (st_r.index[5] && !st_r.mode[6] && $stable(st_r.csel))
        |=> color_out[7:6] == $past(st_r.csel[3:2]))
        else $error("colour set bits wrong");
    // Alternate source for bits 5:4
    csrc_sub_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (st_r.index[5] && st_r.mode[7] && !st_r.mode[6] && $stable(st_r.csel))
        |=> color_out[5:4] == $past(st_r.csel[1:0]))
        else $error("colour bits 5:4 not substituted");
    // Packed pixels pass straight through
    pass_256_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (st_r.index[5] && st_r.mode[6]) |=> color_out == $past(pixel8_in))
        else $error("packed pixel not passed");
    // Host ownership shows the border
    border_show_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!st_r.index[5]) |=> color_out == $past(st_r.border))
        else $error("border not shown while host owns palette");
    // Split-screen suppression of the pan
    pan_force_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (st_r.pan_force) |=> pan_shift_out == 4'h0)
        else $error("pan not forced to zero");
    // Status mux pair
    diag_mux_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (st_r.plane[5:4] == 2'b01) |=> status_diag_out == $past(st_r.color[5:4]))
        else $error("status mux wrong pair");
    // Nine-dot count 8 wraps to zero
    pan_nine_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!st_r.pan_force && nine_dot_in && !st_r.mode[0] && st_r.pan[3:0] == 4'h8)
        |=> pan_shift_out == 4'h0)
        else $error("nine-dot count 8 not zero");
    // Plain graphics pans by the count
    pan_plain_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!st_r.pan_force && st_r.mode[0] && !st_r.mode[6] && st_r.pan[3:0] <= 4'h8)
        |=> pan_shift_out == $past(st_r.pan[3:0]))
        else $error("plain pan count wrong");
    // Packed mode pans by half the count
    pan_half_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!st_r.pan_force && st_r.mode[0] && st_r.mode[6])
        |=> pan_shift_out == {1'b0, $past(st_r.pan[3:1])})
        else $error("packed mode pan not halved");
    // Data write during display leaves the entry untouched
    pal_block_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (io_wr_in && io_addr_in == apc_pkg::ATTR_WR_PORT && st_r.data_phase
        && st_r.index[5] && !st_r.index[4]) |=> ##1 pal_host == $past(pal_host))
        else $error("palette written during display");
endmodule
`default_nettype wire

/* apc_pkg.sv */
// Notes on behaviour
// - Index bits 4:0 select the internal register for the next data access.
// - Reading input status one resets the port pointer to the index.
// - Index bit 5 low lets host load palette; high lets pixels address it.
// - Outside 256-colour mode a 4-bit pixel picks one of 16 entries.
// - In 256-colour mode pixel bytes bypass the palette and index the external lookup table.
// - Mode bit 7 takes colour bits 5:4 from colour-select bits 1:0.
// - Colour-select bits 3:2 give colour output bits 7:6.
// - Mode bit 0 selects text when zero, graphics when one.
// - Line graphics bit copies dot eight into dot nine for codes C0h-DFh.
// - Mode bit 3 makes attribute bit 7 blink, else background intensity.
// - Pan compatibility forces pan zero after line compare until vsync.
// - Plane enable bits 3:0 pass or block each memory map.
// - Plane enable bits 5:4 select colour bit pair for status diagnostics.
// - Pan count shift depends on mode: nine-dot, mode 13h or plain.
package apc_pkg;
    localparam logic [15:0] ATTR_WR_PORT = 16'h03c0;
    localparam logic [15:0] ATTR_RD_PORT = 16'h03c1;
    localparam logic [15:0] STATUS_PORT = 16'h03da;
    localparam logic [4:0] IDX_MODE = 5'h10;
    localparam logic [4:0] IDX_BORDER = 5'h11;
    localparam logic [4:0] IDX_PLANE = 5'h12;
    localparam logic [4:0] IDX_PAN = 5'h13;
    localparam logic [4:0] IDX_CSEL = 5'h14;
    localparam int MODE_GFX_BIT = 0;
    localparam int MODE_LGE_BIT = 2;
    localparam int MODE_BLINK_BIT = 3;
    localparam int MODE_PANC_BIT = 5;
    localparam int MODE_256_BIT = 6;
    localparam int MODE_CSRC_BIT = 7;
    localparam int IDX_PAS_BIT = 5;
    localparam logic [7:0] LG_LO = 8'hc0;
    localparam logic [7:0] LG_HI = 8'hdf;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [5:0] RESET_IDX = 6'h00;
    localparam int BLINK_CYCLES = 16;
endpackage

/* apc_palette_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module apc_palette_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 6
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [$clog2(DEPTH)-1:0] host_addr_in,
    input wire logic [$clog2(DEPTH)-1:0] pix_addr_in,
    output logic [WIDTH-1:0] host_data_out,
    output logic [WIDTH-1:0] pix_data_out
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    // Storage and two registered read ports
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            host_data_out <= '0;
            pix_data_out <= '0;
        end else begin
            if (wr_en_in) begin
                mem_r[wr_addr_in] <= wr_data_in;
            end
            host_data_out <= mem_r[host_addr_in];
            pix_data_out <= mem_r[pix_addr_in];
        end
    end
endmodule
`default_nettype wire

/* apc_dac_model.sv */
`timescale 1ns/1ps
`default_nettype none
module apc_dac_model (
    input wire logic sys_clk_in,
    input wire logic [7:0] color_in,
    output logic [17:0] rgb_out
);
    logic [17:0] lut [256];
    // Colour table filled with a fixed pattern
    initial begin
        for (int i = 0; i < 256; i++) begin
            lut[i] = {i[5:0], ~i[5:0], i[7:2]};
        end
    end
    // Colour code indexes the table one clock later
    always_ff @(posedge sys_clk_in) begin
        rgb_out <= lut[color_in];
    end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, nine = 1'b0, lcmp = 1'b0, vs = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0] io_wdata = 8'h00, pix8 = 8'h00, ccode = 8'h00, attr = 8'h00, e;
    logic [3:0] pix = 4'h0;
    logic ninth = 1'b0, eighth = 1'b0, fgd = 1'b0;
    logic [7:0] rdata, color;
    logic [1:0] diag;
    logic [3:0] pan;
    logic text_m, blink_m;
    logic [17:0] rgb;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    always #2 clk = ~clk;
    apc_top apc_top_i (.sys_clk_in(clk), .rst_in(rst), .io_addr_in(io_addr), .io_wr_in(io_wr),
        .io_rd_in(io_rd), .io_wdata_in(io_wdata), .io_rdata_out(rdata), .status_diag_out(diag),
        .pixel_in(pix), .pixel8_in(pix8), .char_code_in(ccode), .attr_in(attr),
        .ninth_dot_in(ninth), .eighth_dot_in(eighth), .fg_dot_in(fgd), .line_cmp_in(lcmp),
        .vsync_in(vs), .nine_dot_in(nine), .color_out(color), .pan_shift_out(pan),
        .text_mode_out(text_m), .blink_mode_out(blink_m));
    apc_dac_model apc_dac_model_i (.sys_clk_in(clk), .color_in(color), .rgb_out(rgb));
    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One-cycle strobes, launched and dropped on falling edges
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        wt(1);
        io_wr = 1'b0;
        wt(1);
    endtask
    task automatic rd(input logic [15:0] a);
        io_addr = a;
        io_rd = 1'b1;
        wt(1);
        io_rd = 1'b0;
        wt(1);
    endtask
    // Pointer reset, index, data
    task automatic setr(input logic [7:0] idx, input logic [7:0] d);
        rd(apc_pkg::STATUS_PORT);
        wr(apc_pkg::ATTR_WR_PORT, idx);
        wr(apc_pkg::ATTR_WR_PORT, d);
    endtask
    task automatic rdreg(input logic [7:0] idx, input logic [7:0] exp);
        rd(apc_pkg::STATUS_PORT);
        wr(apc_pkg::ATTR_WR_PORT, idx);
        rd(apc_pkg::ATTR_RD_PORT);
        chk({10'h000, rdata}, {10'h000, exp});
    endtask
    // Text dot: code, dots {ninth, eighth, font}, expected palette entry
    task automatic txt(input logic [7:0] cc, input logic [2:0] dots, input logic [5:0] exp);
        ccode = cc;
        {ninth, eighth, fgd} = dots;
        wt(3);
        chk({10'h000, color}, {12'h000, exp});
    endtask
    function automatic logic [5:0] pal(input int i);
        return 6'(i * 5 + 3);
    endfunction
    function automatic logic [3:0] pan_exp(input int c, input int m);
        if (m == 0) return (c == 8) ? 4'h0 : 4'(c + 1);
        if (m == 1) return 4'(c / 2);
        return 4'(c);
    endfunction
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        wt(12);
        rst = 1'b0;
        chk({10'h000, color}, 18'h00000);
        rd(apc_pkg::ATTR_WR_PORT);
        chk({10'h000, rdata}, 18'h00000);
        for (int i = 0; i < 16; i++) setr(8'(i), {2'b00, pal(i)});
        for (int i = 0; i < 16; i++) rdreg(8'(i), {2'b00, pal(i)});
        setr(8'h23, 8'h3f);
        rdreg(8'h23, {2'b00, pal(3)});
        setr(8'h15, 8'hff);
        rdreg(8'h15, 8'h00);
        // Pointer left at data, then status read restores index
        wr(apc_pkg::ATTR_WR_PORT, 8'h11);
        wr(apc_pkg::ATTR_WR_PORT, 8'h15);
        setr(8'h11, 8'h2a);
        wt(3);
        chk({10'h000, color}, 18'h0002a);
        setr(8'h32, 8'h0f);
        setr(8'h34, 8'h00);
        setr(8'h30, 8'h01);
        chk({17'h00000, text_m}, 18'h00000);
        for (int p = 0; p < 16; p++) begin
            pix = 4'(p);
            wt(3);
            chk({10'h000, color}, {12'h000, pal(p)});
        end
        setr(8'h34, 8'h0e);
        setr(8'h30, 8'h81);
        pix = 4'h5;
        e = {4'he, 4'(pal(5))};
        wt(3);
        chk({10'h000, color}, {10'h000, e});
        for (int s = 0; s < 4; s++) begin
            setr(8'h32, {2'b00, 2'(s), 4'hf});
            wt(4);
            chk({16'h0000, diag}, (s == 0) ? {e[2], e[0]} : (s == 1) ? {e[5], e[4]} :
                (s == 2) ? {e[3], e[1]} : {e[7], e[6]});
        end
        setr(8'h32, 8'h05);
        pix = 4'hf;
        wt(3);
        chk({10'h000, color}, {10'h000, 4'he, 4'(pal(5))});
        setr(8'h30, 8'h41);
        pix8 = 8'h9c;
        wt(4);
        chk({10'h000, color}, 18'h0009c);
        chk(rgb, {6'h1c, 6'h23, 6'h27});
        for (int m = 0; m < 3; m++) begin
            nine = (m == 0);
            setr(8'h30, (m == 0) ? 8'h00 : (m == 1) ? 8'h41 : 8'h01);
            for (int c = 0; c < 9; c++) begin
                setr(8'h33, 8'(c));
                wt(3);
                chk({14'h0000, pan}, {14'h0000, pan_exp(c, m)});
            end
        end
        setr(8'h30, 8'h08);
        chk({17'h00000, text_m}, 18'h00001);
        chk({17'h00000, blink_m}, 18'h00001);
        setr(8'h30, 8'h21);
        setr(8'h33, 8'h03);
        lcmp = 1'b1;
        wt(1);
        lcmp = 1'b0;
        wt(10);
        chk({14'h0000, pan}, 18'h00000);
        vs = 1'b1;
        wt(4);
        vs = 1'b0;
        wt(8);
        chk({14'h0000, pan}, 18'h00003);
        setr(8'h30, 8'h01);
        lcmp = 1'b1;
        wt(3);
        chk({14'h0000, pan}, 18'h00003);
        // Text path: nine-dot copy, font dot, background intensity and blink-mode background
        setr(8'h32, 8'h0f);
        setr(8'h34, 8'h00);
        setr(8'h30, 8'h04);
        attr = 8'h9a;
        txt(8'hc5, 3'b110, pal(10));
        txt(8'h41, 3'b110, pal(9));
        txt(8'h41, 3'b001, pal(10));
        txt(8'h41, 3'b000, pal(9));
        setr(8'h30, 8'h0c);
        txt(8'h41, 3'b000, pal(1));
        end_sim();
    end
endmodule
`default_nettype wire
